// file: asx_pkg.sv
// constants, field layout and register map of the atomic swap executor
package asx_pkg;

  // instruction field positions
  localparam int ASX_SIZE_HI   = 31;
  localparam int ASX_SIZE_LO   = 30;
  localparam int ASX_FAM_HI    = 29;
  localparam int ASX_FAM_LO    = 24;
  localparam int ASX_ACQ_BIT   = 23;
  localparam int ASX_REL_BIT   = 22;
  localparam int ASX_ONE_BIT   = 21;
  localparam int ASX_SRC_HI    = 20;
  localparam int ASX_SRC_LO    = 16;
  localparam int ASX_OP_HI     = 15;
  localparam int ASX_OP_LO     = 12;
  localparam int ASX_ZB_HI     = 11;
  localparam int ASX_ZB_LO     = 10;
  localparam int ASX_BASE_HI   = 9;
  localparam int ASX_BASE_LO   = 5;
  localparam int ASX_TGT_HI    = 4;
  localparam int ASX_TGT_LO    = 0;

  // fixed encoding values
  localparam logic [5:0] ASX_FAM_CODE   = 6'h38;
  localparam logic [3:0] ASX_SWAP_CODE  = 4'h8;
  localparam logic [4:0] ASX_ZERO_IDX   = 5'h1f;
  localparam logic [4:0] ASX_SP_IDX     = 5'h1f;
  localparam logic [1:0] ASX_SIZE_BYTE  = 2'h0;
  localparam logic [1:0] ASX_SIZE_HALF  = 2'h1;
  localparam logic [1:0] ASX_SIZE_WORD  = 2'h2;
  localparam logic [1:0] ASX_SIZE_DWORD = 2'h3;
  localparam int         ASX_SP_ALIGN_BITS = 4;

  // register map
  localparam logic [7:0] ASX_OFS_CTRL   = 8'h00;
  localparam logic [7:0] ASX_OFS_STATUS = 8'h04;
  localparam logic [7:0] ASX_OFS_MASK   = 8'h08;
  localparam logic [7:0] ASX_OFS_COUNT  = 8'h0c;
  localparam logic [7:0] ASX_OFS_ADDR   = 8'h10;

  // control and status fields
  localparam int          ASX_CTRL_SPCHK  = 0;
  localparam logic [31:0] ASX_CTRL_RESET  = 32'h0000_0001;
  localparam int          ASX_ST_DONE     = 0;
  localparam int          ASX_ST_UNDEF    = 1;
  localparam int          ASX_ST_FAULT    = 2;
  localparam int          ASX_ST_OTHER    = 3;
  localparam int          ASX_ST_WIDTH    = 4;
  localparam logic [3:0]  ASX_ST_RESET    = 4'h0;
  localparam logic [3:0]  ASX_MASK_RESET  = 4'h0;

endpackage

// file: asx_decode.sv
// combinational decode of the atomic memory operation encoding
`timescale 1ns/10ps
`default_nettype none
module asx_decode
  import asx_pkg::*;
(
  // instruction word
  input  wire logic [31:0] insn,
  input  wire logic        atomic_ext_present,
  // decoded fields
  output logic       undefined,
  output logic       is_swap,
  output logic       is_other_op,
  output logic [1:0] size,
  output logic [4:0] source_index,
  output logic [4:0] target_index,
  output logic [4:0] base_index,
  output logic       ordered_read,
  output logic       ordered_write,
  output logic       target_zero
);
  wire       family_hit;
  wire [3:0] op_code;
  wire       op_high_bit;
  wire       acq_bit;
  wire       rel_bit;

  assign family_hit   = (insn[ASX_FAM_HI:ASX_FAM_LO] == ASX_FAM_CODE) && insn[ASX_ONE_BIT] &&
                        (insn[ASX_ZB_HI:ASX_ZB_LO] == 2'h0);
  assign op_code      = insn[ASX_OP_HI:ASX_OP_LO];
  assign op_high_bit  = op_code[3];
  assign acq_bit      = insn[ASX_ACQ_BIT];
  assign rel_bit      = insn[ASX_REL_BIT];
  // RL13 operand fields
  assign source_index = insn[ASX_SRC_HI:ASX_SRC_LO];
  assign target_index = insn[ASX_TGT_HI:ASX_TGT_LO];
  assign base_index   = insn[ASX_BASE_HI:ASX_BASE_LO];
  // RL2 size field
  assign size         = insn[ASX_SIZE_HI:ASX_SIZE_LO];
  assign target_zero  = (target_index == ASX_ZERO_IDX);
  // RL9 operation select
  assign is_swap      = family_hit && (op_code == ASX_SWAP_CODE);
  assign is_other_op  = family_hit && !op_high_bit;
  // RL10 missing extension
  assign undefined    = !atomic_ext_present || !(is_swap || is_other_op);
  // RL8 ordering variants
  // RL5 RL7 acquire dropped for zero target
  assign ordered_read  = acq_bit && !target_zero;
  // RL6 release on write
  assign ordered_write = rel_bit;
endmodule
`default_nettype wire

// file: asx_regs.sv
// control, status, mask and interrupt registers of the swap executor
`timescale 1ns/10ps
`default_nettype none
module asx_regs
  import asx_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic [31:0]      reg_rdata,
  // block state
  input  wire logic [ASX_ST_WIDTH-1:0] events,
  input  wire logic [31:0] swap_count,
  input  wire logic [31:0] last_addr,
  output logic             sp_check_en,
  output logic             irq
);
  logic [31:0]             ctrl;
  logic [ASX_ST_WIDTH-1:0] status;
  logic [ASX_ST_WIDTH-1:0] mask;

  wire                    hit_ctrl   = reg_addr == ASX_OFS_CTRL;
  wire                    hit_status = reg_addr == ASX_OFS_STATUS;
  wire                    hit_mask   = reg_addr == ASX_OFS_MASK;
  wire                    hit_count  = reg_addr == ASX_OFS_COUNT;
  wire                    hit_addr   = reg_addr == ASX_OFS_ADDR;
  wire [ASX_ST_WIDTH-1:0] clr        = (reg_write && hit_status) ? reg_wdata[ASX_ST_WIDTH-1:0] : ASX_ST_RESET;
  // a new event beats a simultaneous write-one clear
  wire [ASX_ST_WIDTH-1:0] next_status = (status & ~clr) | events;
  wire [31:0]             next_rdata  =
    !reg_read  ? 32'h0 :
    hit_ctrl   ? {31'h0, ctrl[ASX_CTRL_SPCHK]} :
    hit_status ? {{(32-ASX_ST_WIDTH){1'b0}}, status} :
    hit_mask   ? {{(32-ASX_ST_WIDTH){1'b0}}, mask} :
    hit_count  ? swap_count :
    hit_addr   ? last_addr : 32'h0;

  assign sp_check_en = ctrl[ASX_CTRL_SPCHK];

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      ctrl      <= ASX_CTRL_RESET;
      status    <= ASX_ST_RESET;
      mask      <= ASX_MASK_RESET;
      reg_rdata <= 32'h0;
      irq       <= 1'b0;
    end else begin
      if (reg_write && hit_ctrl) ctrl <= reg_wdata & ASX_CTRL_RESET;
      if (reg_write && hit_mask) mask <= reg_wdata[ASX_ST_WIDTH-1:0];
      status    <= next_status;
      reg_rdata <= next_rdata;
      irq       <= |(next_status & mask);
    end
  end
endmodule
`default_nettype wire

// file: asx_exec.sv
// atomic swap executor: decode, operand fetch, locked read-then-write, writeback
// What this block does
// RL1 - reads the addressed location, writes the source value there, and returns the old value to the target.
// RL2 - size 10 is a word swap and size 11 a doubleword swap, the access being eight bits shifted by size.
// RL3 - the byte form touches one byte and uses only 32-bit views of its registers.
// RL4 - the halfword form touches one halfword and uses only 32-bit views of its registers.
// RL5 - acquire bit set with a target other than 11111 makes the read acquire-ordered, else unordered.
// RL6 - release bit set makes the write release-ordered, else unordered.
// RL7 - a zero-register target never gets acquire ordering.
// RL8 - bits 23 and 22 select none, acquire, release or both.
// RL9 - operation code 1000 is the swap, 0000 to 0111 are the other atomics, the rest is unallocated.
// RL10 - without the atomic extension every encoding is undefined and memory is not touched.
// RL11 - base index 31 takes the stack pointer with an alignment check, else the indexed register.
// RL12 - the loaded value is zero-extended to 64 bits for doublewords and 32 bits otherwise.
// RL13 - store value from bits 20 to 16, destination from the target field, address from the base field.
// RL14 - read and write of one swap are one indivisible access with no write interleaved.
// RL15 - a release write waits for all earlier accesses, an acquire read holds back all later ones.
// RL16 - the target is written only after read data return and never on a fault or undefined encoding.
`timescale 1ns/10ps
`default_nettype none
module asx_exec
  import asx_pkg::*;
#(
  parameter int  XLEN       = 64,
  parameter bit  ATOMIC_EXT = 1'b1
)
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  // instruction issue
  input  wire logic [31:0] insn,
  input  wire logic        insn_valid,
  output logic             insn_ready,
  // register file read (data valid in the cycle the index is shown)
  output logic [4:0]       rf_src_index,
  output logic [4:0]       rf_base_index,
  input  wire logic [XLEN-1:0] rf_src_data,
  input  wire logic [XLEN-1:0] rf_base_data,
  input  wire logic [XLEN-1:0] stack_pointer,
  // register file writeback
  output logic             wb_valid,
  output logic [4:0]       wb_index,
  output logic [XLEN-1:0]  wb_data,
  output logic             wb_wide,
  // coherent memory
  output logic             mem_req,
  output logic             mem_write,
  output logic [XLEN-1:0]  mem_addr,
  output logic [XLEN-1:0]  mem_wdata,
  output logic [1:0]       mem_size,
  output logic             mem_ordered,
  output logic             mem_lock,
  input  wire logic        mem_ack,
  input  wire logic        mem_fault,
  input  wire logic [XLEN-1:0] mem_rdata,
  // ordering with the rest of the core
  input  wire logic        earlier_drained,
  output logic             later_hold,
  // outcome pulses
  output logic             swap_done,
  output logic             undef_insn,
  output logic             align_fault,
  output logic             other_op,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic [31:0]      reg_rdata,
  output logic             irq
);
  initial begin
    if (XLEN != 64) $error("asx_exec supports only a 64-bit register width");
  end

  typedef enum logic [2:0] {
    ASX_IDLE,
    ASX_OPND,
    ASX_RD,
    ASX_WRPREP,
    ASX_WR,
    ASX_WB
  } asx_state_t;

  asx_state_t state;
  logic [31:0]     cur_insn;
  logic [XLEN-1:0] swap_value;
  logic [XLEN-1:0] old_data;
  logic [31:0]     swap_count;
  logic [31:0]     last_addr;
  logic            sp_check_en;

  // decode of the word on the issue port and of the held word
  wire       in_undef;
  wire       in_swap;
  wire       in_other;
  wire [4:0] in_src;
  wire [4:0] in_base;
  wire       d_undef;
  wire       d_swap;
  wire       d_other;
  wire [1:0] d_size;
  wire [4:0] d_src;
  wire [4:0] d_tgt;
  wire [4:0] d_base;
  wire       d_ord_rd;
  wire       d_ord_wr;
  wire       d_tzero;

  asx_decode u_dec_in (
    .insn               (insn),
    .atomic_ext_present (ATOMIC_EXT),
    .undefined          (in_undef),
    .is_swap            (in_swap),
    .is_other_op        (in_other),
    .size               (),
    .source_index       (in_src),
    .target_index       (),
    .base_index         (in_base),
    .ordered_read       (),
    .ordered_write      (),
    .target_zero        ()
  );

  asx_decode u_dec_cur (
    .insn               (cur_insn),
    .atomic_ext_present (ATOMIC_EXT),
    .undefined          (d_undef),
    .is_swap            (d_swap),
    .is_other_op        (d_other),
    .size               (d_size),
    .source_index       (d_src),
    .target_index       (d_tgt),
    .base_index         (d_base),
    .ordered_read       (d_ord_rd),
    .ordered_write      (d_ord_wr),
    .target_zero        (d_tzero)
  );

  // access width mask: 8 << size bits
  wire [XLEN-1:0] size_mask =
    (d_size == ASX_SIZE_BYTE)  ? 64'h0000_0000_0000_00ff :
    (d_size == ASX_SIZE_HALF)  ? 64'h0000_0000_0000_ffff :
    (d_size == ASX_SIZE_WORD)  ? 64'h0000_0000_ffff_ffff : 64'hffff_ffff_ffff_ffff;
  // RL11 stack pointer or indexed base
  wire            base_is_sp = (d_base == ASX_SP_IDX);
  wire [XLEN-1:0] next_addr  = base_is_sp ? stack_pointer : rf_base_data;
  wire            sp_misalign = base_is_sp && sp_check_en && (next_addr[ASX_SP_ALIGN_BITS-1:0] != 4'h0);
  // every access must sit on an eight-byte boundary, whatever its size
  wire [XLEN-1:0] size_low   = size_mask >> 3;
  wire            data_misalign = (next_addr & size_low[XLEN-1:0] & 64'h7) != 64'h0;
  // RL3 RL4 RL2 narrow views of the source register
  wire [XLEN-1:0] next_value = rf_src_data & size_mask;
  // RL12 zero extension of returned data
  wire [XLEN-1:0] next_old   = mem_rdata & size_mask;
  wire            wide       = (d_size == ASX_SIZE_DWORD);
  wire            accept     = insn_valid && insn_ready;
  // RL15 release write waits for earlier accesses
  wire            write_go   = !d_ord_wr || earlier_drained;

  wire [ASX_ST_WIDTH-1:0] events = {other_op, align_fault, undef_insn, swap_done};

  asx_regs u_regs (
    .ref_clk     (ref_clk),
    .reset_n     (reset_n),
    .reg_addr    (reg_addr),
    .reg_wdata   (reg_wdata),
    .reg_write   (reg_write),
    .reg_read    (reg_read),
    .reg_rdata   (reg_rdata),
    .events      (events),
    .swap_count  (swap_count),
    .last_addr   (last_addr),
    .sp_check_en (sp_check_en),
    .irq         (irq)
  );

  // sequencing and pulses
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      state       <= ASX_IDLE;
      insn_ready  <= 1'b0;
      cur_insn    <= 32'h0;
      undef_insn  <= 1'b0;
      other_op    <= 1'b0;
      align_fault <= 1'b0;
      swap_done   <= 1'b0;
      later_hold  <= 1'b0;
    end else begin
      undef_insn  <= 1'b0;
      other_op    <= 1'b0;
      align_fault <= 1'b0;
      swap_done   <= 1'b0;
      case (state)
        ASX_IDLE: begin
          insn_ready <= 1'b1;
          if (accept) begin
            insn_ready <= 1'b0;
            cur_insn   <= insn;
            // RL10 RL9 undefined never reaches memory
            if (in_undef) begin
              undef_insn <= 1'b1;
            end else if (in_other) begin
              other_op <= 1'b1;
            end else if (in_swap) begin
              state <= ASX_OPND;
            end
          end
        end
        ASX_OPND: begin
          if (sp_misalign || data_misalign) begin
            align_fault <= 1'b1;
            state       <= ASX_IDLE;
          end else begin
            // RL15 later accesses held while acquire read is open
            later_hold <= d_ord_rd;
            state      <= ASX_RD;
          end
        end
        ASX_RD: begin
          if (mem_ack) begin
            later_hold <= 1'b0;
            if (mem_fault) begin
              align_fault <= 1'b1;
              state       <= ASX_IDLE;
            end else begin
              state <= ASX_WRPREP;
            end
          end
        end
        ASX_WRPREP: begin
          if (write_go) state <= ASX_WR;
        end
        ASX_WR: begin
          if (mem_ack) begin
            if (mem_fault) begin
              align_fault <= 1'b1;
              state       <= ASX_IDLE;
            end else begin
              swap_done <= 1'b1;
              state     <= ASX_WB;
            end
          end
        end
        ASX_WB: begin
          state <= ASX_IDLE;
        end
        default: begin
          state <= ASX_IDLE;
        end
      endcase
    end
  end

  // memory side: lock spans read and write so nothing is slipped in between
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      mem_req     <= 1'b0;
      mem_write   <= 1'b0;
      mem_addr    <= 64'h0;
      mem_wdata   <= 64'h0;
      mem_size    <= ASX_SIZE_BYTE;
      mem_ordered <= 1'b0;
      mem_lock    <= 1'b0;
      swap_value  <= 64'h0;
      old_data    <= 64'h0;
    end else begin
      if (state == ASX_OPND && !(sp_misalign || data_misalign)) begin
        // RL1 RL5 read phase
        mem_req     <= 1'b1;
        mem_write   <= 1'b0;
        mem_addr    <= next_addr;
        mem_size    <= d_size;
        mem_ordered <= d_ord_rd;
        // RL14 lock opened
        mem_lock    <= 1'b1;
        swap_value  <= next_value;
      end else if (state == ASX_RD && mem_ack) begin
        mem_req  <= 1'b0;
        old_data <= next_old;
        if (mem_fault) mem_lock <= 1'b0;
      end else if (state == ASX_WRPREP && write_go) begin
        // RL1 RL6 write phase at the same address
        mem_req     <= 1'b1;
        mem_write   <= 1'b1;
        mem_wdata   <= swap_value;
        mem_ordered <= d_ord_wr;
      end else if (state == ASX_WR && mem_ack) begin
        mem_req   <= 1'b0;
        mem_write <= 1'b0;
        // RL14 lock closed after the write
        mem_lock  <= 1'b0;
      end
    end
  end

  // register file side
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      rf_src_index  <= 5'h0;
      rf_base_index <= 5'h0;
      wb_valid      <= 1'b0;
      wb_index      <= 5'h0;
      wb_data       <= 64'h0;
      wb_wide       <= 1'b0;
      swap_count    <= 32'h0;
      last_addr     <= 32'h0;
    end else begin
      wb_valid <= 1'b0;
      if (accept) begin
        // RL13 operand indices
        rf_src_index  <= in_src;
        rf_base_index <= in_base;
      end
      if (state == ASX_WR && mem_ack && !mem_fault) begin
        // RL16 RL12 writeback only after a clean swap
        wb_valid   <= !d_tzero;
        wb_index   <= d_tgt;
        wb_data    <= old_data;
        wb_wide    <= wide;
        swap_count <= swap_count + 32'h1;
        last_addr  <= mem_addr[31:0];
      end
    end
  end
endmodule
`default_nettype wire

// file: asx_exec_checker.sv
// concurrent checks on the ports of the atomic swap executor
`timescale 1ns/10ps
`default_nettype none
module asx_exec_checker
  import asx_pkg::*;
#(
  parameter int XLEN = 64
)
(
  // clock and reset
  input wire logic            ref_clk,
  input wire logic            reset_n,
  // writeback
  input wire logic            wb_valid,
  input wire logic [4:0]      wb_index,
  input wire logic [XLEN-1:0] wb_data,
  input wire logic            wb_wide,
  // memory and ordering
  input wire logic            mem_req,
  input wire logic            mem_write,
  input wire logic [XLEN-1:0] mem_addr,
  input wire logic [XLEN-1:0] mem_wdata,
  input wire logic [1:0]      mem_size,
  input wire logic            mem_ordered,
  input wire logic            mem_lock,
  input wire logic            mem_ack,
  input wire logic            mem_fault,
  input wire logic            earlier_drained,
  input wire logic            later_hold,
  // outcomes
  input wire logic            swap_done,
  input wire logic            undef_insn,
  input wire logic            align_fault,
  input wire logic            irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  req_hold_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_write))
    else $error("request moved early");
  req_release_a: assert property (mem_req && mem_ack |=> !mem_req)
    else $error("request kept");
  lock_cover_a: assert property (mem_req |-> mem_lock)
    else $error("access unlocked");
  release_wait_a: assert property ($rose(mem_req) && mem_write && mem_ordered |-> $past(earlier_drained))
    else $error("release too early");
  acquire_hold_a: assert property (mem_req && !mem_write && mem_ordered |-> later_hold)
    else $error("acquire without hold");
  zero_target_a: assert property (wb_valid |-> wb_index != ASX_ZERO_IDX)
    else $error("writeback to zero register");
  zero_extend_a: assert property (wb_valid && !wb_wide |-> wb_data[63:32] == 32'h0)
    else $error("not zero extended");
  narrow_data_a: assert property (mem_req && mem_write && mem_size != ASX_SIZE_DWORD
    |-> (mem_wdata >> (8 << mem_size)) == '0)
    else $error("store data too wide");
  done_after_ack_a: assert property (swap_done |-> $past(mem_ack && mem_write && !mem_fault))
    else $error("done without ack");
  fault_no_wb_a: assert property (mem_ack && mem_fault |=> !wb_valid [*2])
    else $error("writeback after fault");
  undef_quiet_a: assert property (undef_insn |-> !mem_req && !wb_valid)
    else $error("undefined touched memory");

  swap_wide_c: cover property (swap_done && wb_wide);
  fault_c: cover property (align_fault);
  irq_c: cover property (irq);
endmodule

bind asx_exec asx_exec_checker #(.XLEN(XLEN)) chk (.*);
`default_nettype wire

// file: asx_mem_model.sv
// coherent memory model with one location, answering fast or slow
`timescale 1ns/10ps
`default_nettype none
module asx_mem_model (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        reset_n,
  // request
  input wire logic        mem_req,
  input wire logic        mem_write,
  input wire logic [63:0] mem_wdata,
  input wire logic [1:0]  mem_size,
  input wire logic        mem_lock,
  // scenario knobs
  input wire logic        slow,
  input wire logic        fail,
  // answer
  output logic            mem_ack,
  output logic            mem_fault,
  output logic [63:0]     mem_rdata
);
  logic [63:0] store;
  logic [63:0] keep;
  logic [2:0]  wait_cnt;
  assign keep = (mem_size == 2'h3) ? 64'hffff_ffff_ffff_ffff : ((64'h1 << (8 << mem_size)) - 64'h1);
  // outside an answer the bus shows the inverse so a stale capture cannot match
  assign mem_rdata = mem_ack ? store : ~store;
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      mem_ack <= 1'b0;
      mem_fault <= 1'b0;
      wait_cnt <= 3'h0;
      store <= 64'h8899_aabb_ccdd_eeff;
    end else begin
      mem_ack <= 1'b0;
      mem_fault <= 1'b0;
      if (mem_req && !mem_ack) begin
        if (wait_cnt >= (slow ? 3'h3 : 3'h0)) begin
          mem_ack <= 1'b1;
          mem_fault <= fail;
          wait_cnt <= 3'h0;
          // write lands only inside the lock
          if (mem_write && mem_lock && !fail) begin
            store <= (store & ~keep) | (mem_wdata & keep);
          end
        end else begin
          wait_cnt <= wait_cnt + 3'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: tb_atomic_swap_exec.sv
// self-checking testbench of the atomic swap executor
`timescale 1ns/10ps
`default_nettype none
module tb_atomic_swap_exec
  import asx_pkg::*;
;
  logic        ref_clk = 1'b0, reset_n = 1'b0, insn_valid = 1'b0, earlier_drained = 1'b1;
  logic        reg_write = 1'b0, reg_read = 1'b0, slow = 1'b0, fail = 1'b0;
  logic [31:0] insn = 32'h0, reg_wdata = 32'h0;
  logic [7:0]  reg_addr = 8'h0;
  logic [63:0] base_addr = 64'h0000_2000_0000_0000, stack_pointer = 64'h0000_0000_1000_0000;
  wire logic [63:0] rf_src_data, rf_base_data, mem_addr, mem_wdata, mem_rdata, wb_data;
  wire logic [31:0] reg_rdata;
  wire logic [4:0]  rf_src_index, rf_base_index, wb_index;
  wire logic [1:0]  mem_size;
  wire logic insn_ready, wb_valid, wb_wide, mem_req, mem_write, mem_ordered, mem_lock, mem_ack;
  wire logic mem_fault, later_hold, swap_done, undef_insn, align_fault, other_op, irq;
  int errors = 0, checked = 0, cycles = 0, nfin = 0, nwb = 0, nwr = 0;
  logic [3:0]  kind;
  logic [1:0]  rd_size;
  logic [4:0]  wb_i;
  logic        rd_ord, wr_ord, wb_w;
  logic [63:0] rd_addr, wr_data, wb_d;

  // register file stand-in: values depend on the index so field mix-ups show
  assign rf_src_data = {32'h9abc_def1, 24'h5a_5a5a, 3'h0, rf_src_index};
  assign rf_base_data = base_addr + {56'h0, rf_base_index, 3'h0};

  asx_exec #(.XLEN(64), .ATOMIC_EXT(1'b1)) dut (.*);
  asx_mem_model mdl (.*);

  always #4 ref_clk = ~ref_clk;

  always @(posedge ref_clk) begin
    if (mem_req && mem_ack && !mem_write) begin
      rd_ord <= mem_ordered;
      rd_addr <= mem_addr;
      rd_size <= mem_size;
    end
    if (mem_req && mem_ack && mem_write) begin
      wr_ord <= mem_ordered;
      wr_data <= mem_wdata;
      nwr <= nwr + 1;
    end
    if (wb_valid) begin
      nwb <= nwb + 1;
      wb_d <= wb_data;
      wb_w <= wb_wide;
      wb_i <= wb_index;
    end
    if (swap_done | undef_insn | align_fault | other_op) begin
      nfin <= nfin + 1;
      kind <= {swap_done, undef_insn, align_fault, other_op};
    end
  end

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // a hang costs one mismatch and ends the run
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      finish_test;
    end
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [31:0] mk(input logic [1:0] sz, input logic a, input logic r, input logic [3:0] op,
                                     input logic [4:0] s, input logic [4:0] b, input logic [4:0] t);
    return {sz, ASX_FAM_CODE, a, r, 1'b1, s, op, 2'h0, b, t};
  endfunction

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge ref_clk);
    reg_write <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge ref_clk);
    reg_read <= 1'b0;
    @(posedge ref_clk);
    check(reg_rdata, exp);
  endtask

  task automatic issue(input logic [31:0] w);
    int n0;
    int k;
    n0 = nfin;
    k = 0;
    while (insn_ready !== 1'b1 && k < 50) begin
      @(posedge ref_clk);
      k++;
    end
    insn <= w;
    insn_valid <= 1'b1;
    @(posedge ref_clk);
    insn_valid <= 1'b0;
    k = 0;
    while (nfin == n0 && k < 200) begin
      @(posedge ref_clk);
      k++;
    end
    check(nfin, n0 + 1);
    repeat (3) @(posedge ref_clk);
  endtask

  task automatic sw(input logic [1:0] sz, input logic a, input logic r, input logic [4:0] s,
                    input logic [4:0] b, input logic [4:0] t);
    logic [63:0] m;
    logic [63:0] old;
    logic [63:0] src;
    int w0;
    m = (sz == 2'h3) ? 64'hffff_ffff_ffff_ffff : ((64'h1 << (8 << sz)) - 64'h1);
    old = mdl.store;
    src = {32'h9abc_def1, 24'h5a_5a5a, 3'h0, s};
    w0 = nwb;
    issue(mk(sz, a, r, ASX_SWAP_CODE, s, b, t));
    check(kind, 4'h8);
    check(rd_addr, (b == 5'h1f) ? stack_pointer : base_addr + {56'h0, b, 3'h0});
    check(rd_size, sz);
    check(rd_ord, a && t != 5'h1f);
    check(wr_ord, r);
    check(wr_data, src & m);
    check(mdl.store, (old & ~m) | (src & m));
    check(nwb, w0 + (t != 5'h1f));
    if (t != 5'h1f) begin
      check(wb_d, old & m);
      check(wb_w, sz == 2'h3);
      check(wb_i, t);
    end
  endtask

  task automatic t_regs;
    reg_rd(ASX_OFS_CTRL, 32'h1);
    reg_rd(ASX_OFS_STATUS, 32'h0);
    reg_rd(ASX_OFS_MASK, 32'h0);
    reg_rd(8'h40, 32'h0);
    check(irq, 1'b0);
    $display("register reset done");
  endtask

  task automatic t_variants;
    for (int i = 0; i < 16; i++) begin
      slow <= i[0];
      sw(i[3:2], i[1], i[0], 5'(i + 1), 5'h2, 5'h9);
    end
    $display("variants done");
  endtask

  task automatic t_special;
    int n0;
    sw(2'h2, 1'b1, 1'b1, 5'h4, 5'h3, 5'h1f);
    sw(2'h3, 1'b1, 1'b0, 5'h6, 5'h1f, 5'ha);
    stack_pointer <= 64'h0000_0000_1000_0008;
    n0 = nwr;
    issue(mk(2'h3, 1'b0, 1'b0, ASX_SWAP_CODE, 5'h6, 5'h1f, 5'ha));
    check(kind, 4'h2);
    check(nwr, n0);
    stack_pointer <= 64'h0000_0000_1000_0000;
    earlier_drained <= 1'b0;
    fork
      sw(2'h1, 1'b0, 1'b1, 5'h7, 5'h4, 5'h5);
      begin
        repeat (20) @(posedge ref_clk);
        check(nwr, n0);
        earlier_drained <= 1'b1;
      end
    join
    $display("special cases done");
  endtask

  task automatic t_ops;
    for (int op = 0; op < 16; op++) begin
      issue(mk(2'h2, 1'b0, 1'b0, 4'(op), 5'h1, 5'h2, 5'h3));
      check(kind, (op < 8) ? 4'h1 : ((op == 8) ? 4'h8 : 4'h4));
    end
    $display("operation codes done");
  endtask

  task automatic t_fault;
    int w0;
    int n0;
    w0 = nwb;
    n0 = nwr;
    fail <= 1'b1;
    issue(mk(2'h3, 1'b1, 1'b1, ASX_SWAP_CODE, 5'h1, 5'h2, 5'h3));
    check(kind, 4'h2);
    check(nwb, w0);
    check(nwr, n0);
    fail <= 1'b0;
    $display("memory fault done");
  endtask

  task automatic t_irq;
    reg_rd(ASX_OFS_STATUS, 32'hf);
    reg_rd(ASX_OFS_COUNT, 32'h14);
    reg_wr(ASX_OFS_MASK, 32'h4);
    repeat (2) @(posedge ref_clk);
    check(irq, 1'b1);
    reg_wr(ASX_OFS_STATUS, 32'h4);
    repeat (2) @(posedge ref_clk);
    check(irq, 1'b0);
    reg_wr(8'h40, 32'hffff_ffff);
    reg_rd(8'h40, 32'h0);
    reg_rd(ASX_OFS_STATUS, 32'hb);
    $display("interrupt done");
  endtask

  initial begin
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    t_regs;
    t_variants;
    t_special;
    t_ops;
    t_fault;
    t_irq;
    finish_test;
  end
endmodule
`default_nettype wire
